// ### design/pos_pid_pkg.sv
/*
 package for the closed-loop position controller: register map,
 field layout, timing constants and shared types.
 assumes a 100 MHz clock and a simple strobe register port.
*/
package pos_pid_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;

  // ------------------------------------------------------------
  // register map (word index)
  // ------------------------------------------------------------
  localparam logic [4:0] A_CTRL   = 5'h00;
  localparam logic [4:0] A_ACCEL  = 5'h01;
  localparam logic [4:0] A_DECEL  = 5'h02;
  localparam logic [4:0] A_VEL    = 5'h03;
  localparam logic [4:0] A_KP     = 5'h04;
  localparam logic [4:0] A_KI     = 5'h05;
  localparam logic [4:0] A_KD     = 5'h06;
  localparam logic [4:0] A_ILIM   = 5'h07;
  localparam logic [4:0] A_TURNS  = 5'h08;
  localparam logic [4:0] A_ITHR   = 5'h09;
  localparam logic [4:0] A_IDUR   = 5'h0A;
  localparam logic [4:0] A_DEST0  = 5'h0B;
  localparam logic [4:0] A_DEST1  = 5'h0C;
  localparam logic [4:0] A_STAT   = 5'h0D;
  localparam logic [4:0] A_MASK   = 5'h0E;
  localparam logic [4:0] A_POWER0 = 5'h0F;
  localparam logic [4:0] A_POWER1 = 5'h10;
  localparam logic [4:0] A_SETPT0 = 5'h11;
  localparam logic [4:0] A_SETPT1 = 5'h12;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int C_TRACK   = 0;   // 1: tracking mode, 0: relative
  localparam int C_TRIGEN  = 1;   // current trigger enable
  localparam int C_TRIGACT = 2;   // 0: emergency stop, 1: limit switch
  localparam int C_ENC     = 3;   // 1: encoder feedback
  localparam int C_ESTCLR  = 4;   // write 1: release emergency stop

  // status / mask bits
  localparam int S_TRIG0 = 0;
  localparam int S_TRIG1 = 1;
  localparam int S_DONE0 = 2;
  localparam int S_DONE1 = 3;
  localparam int S_W     = 4;

  // ------------------------------------------------------------
  // power-up defaults (stand in for stored configuration)
  // ------------------------------------------------------------
  localparam logic [15:0] DEF_ACCEL = 16'h0010;
  localparam logic [15:0] DEF_DECEL = 16'h0010;
  localparam logic [15:0] DEF_VEL   = 16'h0100;
  localparam logic [15:0] DEF_KP    = 16'h0002;
  localparam logic [15:0] DEF_ILIM  = 16'h1000;
  localparam logic [15:0] DEF_TURNS = 16'h0001;
  localparam logic [15:0] DEF_ITHR  = 16'h7FFF;
  localparam logic [15:0] DEF_IDUR  = 16'h0064;

  localparam logic signed [15:0] PWR_MAX = 16'sh03E8;  // +1000
  localparam logic signed [15:0] PWR_MIN = -16'sh03E8; // -1000

  typedef struct packed {
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] vel;
  } profile_t;

  typedef struct packed {
    logic signed [15:0] kp;
    logic signed [15:0] ki;
    logic signed [15:0] kd;
    logic        [15:0] ilim;
  } gains_t;

endpackage

// ### design/closed_loop_position_pid.sv
/*
 two-channel closed-loop position controller with trapezoidal
 profile, pid loop and over-current trigger.
 assumes synchronous inputs on clk and a strobe register port.
*/
// Operation
// RULE1 - over-current held too long fires action
// RULE2 - action is emergency stop or limit
// RULE3 - relative move: accelerate, cruise, decelerate, stop
// RULE4 - profile values loaded from stored defaults
// RULE5 - profile values writable while running
// RULE6 - encoder gives speed and turns directly
// RULE7 - analog feedback uses turns-per-range parameter
// RULE8 - relative mode steps setpoint each millisecond
// RULE9 - tracking mode compares destination, no trajectory
// RULE10 - tracking setpoint changes only on command
// RULE11 - each tick error is desired minus actual
// RULE12 - proportional term is error times gain
// RULE13 - differential term is error change times gain
// RULE14 - integral sums error, scaled by gain
// RULE15 - integrator clamped by limit parameter
// RULE16 - zero error with zero ki gives zero
// RULE17 - one gain set shared by both channels
// RULE18 - output saturated to power range, signed
module closed_loop_position_pid #(
  parameter int TICK = pos_pid_pkg::TICK_CYCLES,
  parameter int CH   = 2
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // register port
  input  wire logic [4:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  // feedback and current sense
  input  wire logic signed [15:0] fbPos     [CH],
  input  wire logic signed [15:0] encSpeed  [CH],
  input  wire logic        [15:0] motorCurr [CH],
  // outputs
  output logic signed [15:0]      power     [CH],
  output logic        [CH-1:0]    emStop,
  output logic        [CH-1:0]    limitSw,
  output logic                    irq
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
    if (v > 48'(pos_pid_pkg::PWR_MAX)) sat16 = pos_pid_pkg::PWR_MAX;
    else if (v < 48'(signed'(pos_pid_pkg::PWR_MIN))) sat16 = pos_pid_pkg::PWR_MIN;
    else sat16 = v[15:0];
  endfunction

  function automatic logic signed [31:0] clampI(input logic signed [31:0] v,
                                                input logic [15:0] lim);
    logic signed [31:0] l;
    l = 32'(lim);
    if (v > l) clampI = l;
    else if (v < -l) clampI = -l;
    else clampI = v;
  endfunction

  // ------------------------------------------------------------
  // tick
  // ------------------------------------------------------------
  logic [31:0] tickCnt_q;
  logic        tick_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tickCnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= (tickCnt_q == 32'(TICK - 1));
      tickCnt_q <= (tickCnt_q == 32'(TICK - 1)) ? '0 : tickCnt_q + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  pos_pid_pkg::profile_t prof_q;
  pos_pid_pkg::gains_t   gain_q;
  logic [4:0]            ctrl_q;
  logic [15:0]           turns_q, ithr_q, idur_q;
  logic [pos_pid_pkg::S_W-1:0] stat_q, mask_q;
  logic signed [15:0]    dest_q [CH];
  logic [CH-1:0]         newCmd_q;
  logic                  wr;
  assign wr = regWr;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prof_q <= '{pos_pid_pkg::DEF_ACCEL, pos_pid_pkg::DEF_DECEL,
                  pos_pid_pkg::DEF_VEL}; // RULE4
      gain_q <= '{pos_pid_pkg::DEF_KP, 16'h0000, 16'h0000, pos_pid_pkg::DEF_ILIM};
      ctrl_q <= 5'h00;
      turns_q <= pos_pid_pkg::DEF_TURNS;
      ithr_q <= pos_pid_pkg::DEF_ITHR;
      idur_q <= pos_pid_pkg::DEF_IDUR;
      mask_q <= '0;
    end else if (wr) begin
      // profile changes apply on the next tick without a mode change
      unique case (regAddr)
        pos_pid_pkg::A_CTRL:  ctrl_q       <= regWdata[4:0];
        pos_pid_pkg::A_ACCEL: prof_q.accel <= regWdata[15:0]; // RULE5
        pos_pid_pkg::A_DECEL: prof_q.decel <= regWdata[15:0]; // RULE5
        pos_pid_pkg::A_VEL:   prof_q.vel   <= regWdata[15:0]; // RULE5
        pos_pid_pkg::A_KP:    gain_q.kp    <= regWdata[15:0];
        pos_pid_pkg::A_KI:    gain_q.ki    <= regWdata[15:0];
        pos_pid_pkg::A_KD:    gain_q.kd    <= regWdata[15:0];
        pos_pid_pkg::A_ILIM:  gain_q.ilim  <= regWdata[15:0];
        pos_pid_pkg::A_TURNS: turns_q      <= regWdata[15:0];
        pos_pid_pkg::A_ITHR:  ithr_q       <= regWdata[15:0];
        pos_pid_pkg::A_IDUR:  idur_q       <= regWdata[15:0];
        pos_pid_pkg::A_MASK:  mask_q       <= regWdata[pos_pid_pkg::S_W-1:0];
        default: ;
      endcase
    end
  end

  // destination and new-command flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int c = 0; c < CH; c++) dest_q[c] <= '0;
      newCmd_q <= '0;
    end else begin
      for (int c = 0; c < CH; c++) begin
        if (wr && regAddr == 5'(pos_pid_pkg::A_DEST0 + c)) begin
          dest_q[c]   <= regWdata[15:0];
          newCmd_q[c] <= 1'b1;
        end else if (tick_q) begin
          newCmd_q[c] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // trajectory, pid and current trigger per channel
  // ------------------------------------------------------------
  logic signed [15:0] setpt_q [CH];
  logic signed [31:0] spAcc_q [CH];   // setpoint with 8 fraction bits
  logic signed [31:0] vel_q   [CH];   // profile speed, 8 fraction bits
  logic signed [31:0] integ_q [CH];
  logic signed [15:0] prevErr_q [CH];
  logic [15:0]        ovCnt_q [CH];
  logic [CH-1:0]      trig, done;
  logic signed [15:0] measSpd_q [CH];

  for (genvar c = 0; c < CH; c++) begin : g_ch
    logic signed [31:0] remain, stopDist, velAbs, vmax, vnext;
    logic signed [16:0] err;
    logic signed [31:0] iNext;
    logic signed [47:0] pidSum;
    logic signed [16:0] dErr;

    always_comb begin
      remain   = 32'(signed'(dest_q[c])) * 32'sh100 - spAcc_q[c];
      velAbs   = vel_q[c] < 0 ? -vel_q[c] : vel_q[c];
      // distance to stop: v^2 / (2*decel); speed and distance share the
      // same 8 fraction bits, so no extra scaling (the +1 avoids divide by 0)
      stopDist = (velAbs * velAbs) / (32'(prof_q.decel) * 32'sh2 + 32'sh1);
      // encoder gives speed directly; otherwise scale range by turns
      vmax     = ctrl_q[pos_pid_pkg::C_ENC] ? 32'(prof_q.vel)
                 : 32'(prof_q.vel) / (32'(turns_q) + 32'sh1); // RULE6 RULE7
      if ((remain < 0 ? -remain : remain) <= stopDist)
        vnext = velAbs > 32'(prof_q.decel) ? velAbs - 32'(prof_q.decel) : 32'sh0;
      else if (velAbs + 32'(prof_q.accel) < vmax)
        vnext = velAbs + 32'(prof_q.accel);
      else
        vnext = vmax; // RULE3
      if (vnext > (remain < 0 ? -remain : remain)) vnext = remain < 0 ? -remain : remain;
      if (remain < 0) vnext = -vnext;
      err    = 17'(setpt_q[c]) - 17'(fbPos[c]); // RULE11
      dErr   = err - 17'(prevErr_q[c]);
      iNext  = clampI(integ_q[c] + 32'(err), gain_q.ilim); // RULE14 RULE15
      // shared gains for every channel
      pidSum = 48'(err) * 48'(gain_q.kp)            // RULE12 RULE16 RULE17
             + 48'(dErr) * 48'(gain_q.kd)           // RULE13
             + 48'(iNext) * 48'(gain_q.ki);         // RULE14
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        spAcc_q[c] <= '0;
        vel_q[c]   <= '0;
        setpt_q[c] <= '0;
      end else if (tick_q) begin
        if (ctrl_q[pos_pid_pkg::C_TRACK]) begin
          if (newCmd_q[c]) setpt_q[c] <= dest_q[c]; // RULE9 RULE10
          spAcc_q[c] <= 32'(signed'(dest_q[c])) * 32'sh100;
          vel_q[c]   <= '0;
        end else begin
          spAcc_q[c] <= spAcc_q[c] + vnext;  // RULE8
          vel_q[c]   <= vnext;
          setpt_q[c] <= 16'((spAcc_q[c] + vnext) >>> 8); // RULE8
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        integ_q[c]   <= '0;
        prevErr_q[c] <= '0;
        power[c]     <= '0;
        measSpd_q[c] <= '0;
      end else if (tick_q) begin
        integ_q[c]   <= iNext;
        prevErr_q[c] <= 16'(err);
        measSpd_q[c] <= encSpeed[c];
        power[c]     <= emStop[c] ? 16'sh0000 : sat16(pidSum); // RULE18
      end
    end

    // a ramp may stall short of the target and creep on; only a stop on it counts
    assign done[c] = tick_q && vel_q[c] != 0 && vnext == 0 && remain == 0; // RULE3
    assign trig[c] = tick_q && ctrl_q[pos_pid_pkg::C_TRIGEN] &&
                     motorCurr[c] > ithr_q && ovCnt_q[c] == idur_q; // RULE1

    always_ff @(posedge clk) begin
      if (!nrst) ovCnt_q[c] <= '0;
      else if (tick_q) begin
        if (motorCurr[c] <= ithr_q) ovCnt_q[c] <= '0;
        else if (ovCnt_q[c] != 16'hFFFF) ovCnt_q[c] <= ovCnt_q[c] + 16'h1; // RULE1
      end
    end

    always_ff @(posedge clk) begin
      if (!nrst) begin
        emStop[c]  <= 1'b0;
        limitSw[c] <= 1'b0;
      end else if (trig[c]) begin
        if (ctrl_q[pos_pid_pkg::C_TRIGACT]) limitSw[c] <= 1'b1; // RULE2
        else emStop[c] <= 1'b1; // RULE2
      end else if (wr && regAddr == pos_pid_pkg::A_CTRL &&
                   regWdata[pos_pid_pkg::C_ESTCLR]) begin
        emStop[c]  <= 1'b0;
        limitSw[c] <= 1'b0;
      end
    end

    AST_PWR_SAT: assert property (@(posedge clk) disable iff (!nrst) // RULE18
      power[c] <= pos_pid_pkg::PWR_MAX && power[c] >= pos_pid_pkg::PWR_MIN)
      else $error("power out of range");
    AST_TRIG_STOP: assert property (@(posedge clk) disable iff (!nrst) // RULE2
      trig[c] && !ctrl_q[pos_pid_pkg::C_TRIGACT] |=> emStop[c])
      else $error("trigger did not stop motor");
    AST_ZERO: assert property (@(posedge clk) disable iff (!nrst) // RULE16
      tick_q && err == 0 && dErr == 0 && gain_q.ki == 0 && !emStop[c]
      |=> power[c] == 0)
      else $error("zero error gave power");

    // checked right after the update, against the limit that update used;
    // the limit is unsigned, so widen it signed before comparing
    AST_ILIM: assert property (@(posedge clk) disable iff (!nrst) // RULE15
      tick_q |=> integ_q[c] <= $signed({16'h0000, $past(gain_q.ilim)}) &&
                 integ_q[c] >= -$signed({16'h0000, $past(gain_q.ilim)}))
      else $error("integrator over limit");

    AST_TRIG_LIMIT: assert property (@(posedge clk) disable iff (!nrst) // RULE2
      trig[c] && ctrl_q[pos_pid_pkg::C_TRIGACT] |=> limitSw[c])
      else $error("trigger did not raise limit switch");

    // a stop may only come from an enabled trigger that has run its duration
    AST_STOP_SRC: assert property (@(posedge clk) disable iff (!nrst) // RULE1
      $rose(emStop[c]) |-> $past(ctrl_q[pos_pid_pkg::C_TRIGEN]) &&
        !$past(ctrl_q[pos_pid_pkg::C_TRIGACT]) &&
        $past(motorCurr[c]) > $past(ithr_q) &&
        $past(ovCnt_q[c]) == $past(idur_q))
      else $error("stop without a qualified trigger");

    AST_STOP_PWR: assert property (@(posedge clk) disable iff (!nrst) // RULE2
      tick_q && emStop[c] |=> power[c] == 16'sh0000)
      else $error("power applied while stopped");

    // corrections land only on the tick, so power stands between ticks
    AST_PWR_HOLD: assert property (@(posedge clk) disable iff (!nrst) // RULE8
      !tick_q |=> $stable(power[c]))
      else $error("power changed between ticks");

    AST_TRACK_HOLD: assert property (@(posedge clk) disable iff (!nrst) // RULE10
      tick_q && ctrl_q[pos_pid_pkg::C_TRACK] && !newCmd_q[c]
      |=> setpt_q[c] == $past(setpt_q[c]))
      else $error("tracking setpoint moved without a command");

    AST_DONE_AT: assert property (@(posedge clk) disable iff (!nrst) // RULE3
      done[c] |-> setpt_q[c] == dest_q[c])
      else $error("move reported done away from its target");

    AST_OVCNT_CLR: assert property (@(posedge clk) disable iff (!nrst) // RULE1
      tick_q && motorCurr[c] <= ithr_q |=> ovCnt_q[c] == 16'h0000)
      else $error("over-current count kept below threshold");
  end

  // ------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) stat_q <= '0;
    else
      stat_q <= (stat_q & ~((wr && regAddr == pos_pid_pkg::A_STAT)
                ? regWdata[pos_pid_pkg::S_W-1:0] : '0)) | {done, trig};
  end

  always_ff @(posedge clk) begin
    if (!nrst) irq <= 1'b0;
    else irq <= |(stat_q & mask_q);
  end

  // ------------------------------------------------------------
  // read back
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) regRdata <= '0;
    else if (regRd) begin
      unique case (regAddr)
        pos_pid_pkg::A_CTRL:   regRdata <= 32'(ctrl_q);
        pos_pid_pkg::A_ACCEL:  regRdata <= 32'(prof_q.accel);
        pos_pid_pkg::A_DECEL:  regRdata <= 32'(prof_q.decel);
        pos_pid_pkg::A_VEL:    regRdata <= 32'(prof_q.vel);
        pos_pid_pkg::A_KP:     regRdata <= 32'(gain_q.kp);
        pos_pid_pkg::A_KI:     regRdata <= 32'(gain_q.ki);
        pos_pid_pkg::A_KD:     regRdata <= 32'(gain_q.kd);
        pos_pid_pkg::A_ILIM:   regRdata <= 32'(gain_q.ilim);
        pos_pid_pkg::A_TURNS:  regRdata <= 32'(turns_q);
        pos_pid_pkg::A_ITHR:   regRdata <= 32'(ithr_q);
        pos_pid_pkg::A_IDUR:   regRdata <= 32'(idur_q);
        pos_pid_pkg::A_DEST0:  regRdata <= 32'(unsigned'(dest_q[0]));
        pos_pid_pkg::A_DEST1:  regRdata <= 32'(unsigned'(dest_q[CH-1]));
        pos_pid_pkg::A_STAT:   regRdata <= 32'(stat_q);
        pos_pid_pkg::A_MASK:   regRdata <= 32'(mask_q);
        pos_pid_pkg::A_POWER0: regRdata <= 32'(unsigned'(power[0]));
        pos_pid_pkg::A_POWER1: regRdata <= 32'(unsigned'(power[CH-1]));
        pos_pid_pkg::A_SETPT0: regRdata <= 32'(unsigned'(setpt_q[0]));
        pos_pid_pkg::A_SETPT1: regRdata <= 32'(unsigned'(setpt_q[CH-1]));
        default:               regRdata <= 32'h0000_0000;
      endcase
    end else regRdata <= '0;
  end

  AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    tick_q |=> !tick_q)
    else $error("tick too frequent");

  // ------------------------------------------------------------
  // tick spacing, bus and interrupt checks
  // ------------------------------------------------------------
  // separate gap counter so the check does not trust the divider it watches
  logic [31:0] tickGap_q;
  always_ff @(posedge clk) begin
    if (!nrst) tickGap_q <= '0;
    else if (tick_q) tickGap_q <= '0;
    else tickGap_q <= tickGap_q + 32'h1;
  end

  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    tick_q |-> tickGap_q >= 32'(TICK - 1) && tickGap_q <= 32'(TICK))
    else $error("tick arrived early");

  AST_TICK_DUE: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    tickGap_q <= 32'(TICK))
    else $error("tick missed");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    !regRd |=> regRdata == 32'h0000_0000)
    else $error("read data outside its read cycle");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!nrst)
    irq == |($past(stat_q & mask_q)))
    else $error("interrupt does not follow masked status");

endmodule

// ### verification/motor_plant_model.sv
/*
 behavioural current sense and position sensor for the position controller.
 assumes the bench sets the sensed position and the phase current.
*/
module motor_plant_model #(
  parameter int CH = 2
) (
  // clock
  input  wire logic               clk,
  // drive from the controller
  input  wire logic signed [15:0] power     [CH],
  // bench settings
  input  wire logic signed [15:0] posSet    [CH],
  input  wire logic        [15:0] currSet   [CH],
  // sensor side
  output logic signed [15:0]      fbPos     [CH],
  output logic signed [15:0]      encSpeed  [CH],
  output logic        [15:0]      motorCurr [CH]
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // sensor
  // ------------------------------------------------------------
  // position is held by the bench so power never moves it: keeps errors exact
  always_ff @(posedge clk) begin
    for (int i = 0; i < CH; i++) begin
      encSpeed[i]  <= posSet[i] - fbPos[i];
      fbPos[i]     <= posSet[i];
      motorCurr[i] <= currSet[i];
    end
  end
endmodule

// ### verification/tb_closed_loop_position_pid.sv
/*
 self-checking bench for the two-channel position controller.
 assumes the register map of the package and a plant model beside it.
*/
module tb_closed_loop_position_pid;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TK = 20;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic [4:0]         regAddr = 5'h00;
  logic [31:0]        regWdata = 32'h0;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [31:0]        regRdata;
  logic signed [15:0] fbPos [2];
  logic signed [15:0] encSpeed [2];
  logic [15:0]        motorCurr [2];
  logic signed [15:0] power [2];
  logic signed [15:0] posSet [2] = '{16'h0000, 16'h0000};
  logic [15:0]        currSet [2] = '{16'h0000, 16'h0000};
  logic [1:0]         emStop;
  logic [1:0]         limitSw;
  logic               irq;
  int                 mismatches = 0;
  int                 cmp_count = 0;
  logic [31:0]        rd;

  always #5 clk = ~clk;

  closed_loop_position_pid #(.TICK(TK), .CH(2)) dut (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .fbPos(fbPos), .encSpeed(encSpeed),
    .motorCurr(motorCurr), .power(power), .emStop(emStop), .limitSw(limitSw), .irq(irq));

  motor_plant_model #(.CH(2)) plant (
    .clk(clk), .power(power), .posSet(posSet), .currSet(currSet),
    .fbPos(fbPos), .encSpeed(encSpeed), .motorCurr(motorCurr));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(nm, {16'h0000, e}, regRdata);
  endtask

  task automatic ticks(input int n);
    repeat (n * TK) @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #900000;
    mismatches++;
    complete_run();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rdchk("accel", pos_pid_pkg::A_ACCEL, pos_pid_pkg::DEF_ACCEL);
    rdchk("decel", pos_pid_pkg::A_DECEL, pos_pid_pkg::DEF_DECEL);
    rdchk("vel", pos_pid_pkg::A_VEL, pos_pid_pkg::DEF_VEL);
    rdchk("kp", pos_pid_pkg::A_KP, pos_pid_pkg::DEF_KP);
    rdchk("ilim", pos_pid_pkg::A_ILIM, pos_pid_pkg::DEF_ILIM);
    rdchk("turns", pos_pid_pkg::A_TURNS, pos_pid_pkg::DEF_TURNS);
    rdchk("unmapped", 5'h1F, 16'h0000);
    // tracking: one shared kp, error is destination minus position
    wr(pos_pid_pkg::A_CTRL, 32'h00000001);
    wr(pos_pid_pkg::A_DEST0, 32'h00000064);
    wr(pos_pid_pkg::A_DEST1, 32'h0000FFCE);
    ticks(3);
    chk("power0", 32'h000000C8, {16'h0000, power[0]});
    chk("power1", 32'h0000FF9C, {16'h0000, power[1]});
    rdchk("setpt0", pos_pid_pkg::A_SETPT0, 16'h0064);
    rdchk("power0 reg", pos_pid_pkg::A_POWER0, 16'h00C8);
    posSet[0] <= 16'sh0064;
    ticks(3);
    chk("power0 zero", 32'h00000000, {16'h0000, power[0]});
    rdchk("setpt0 held", pos_pid_pkg::A_SETPT0, 16'h0064);
    // saturation keeps the sign
    wr(pos_pid_pkg::A_KP, 32'h00000020);
    posSet[0] <= -16'sh0064;
    ticks(3);
    chk("power0 sat", 32'h000003E8, {16'h0000, power[0]});
    chk("power1 sat", 32'h0000FC18, {16'h0000, power[1]});
    // integral alone, clamped at the limit
    wr(pos_pid_pkg::A_KP, 32'h00000000);
    wr(pos_pid_pkg::A_ILIM, 32'h00000005);
    wr(pos_pid_pkg::A_KI, 32'h00000001);
    posSet[0] <= 16'sh005A;
    ticks(20);
    chk("power0 integ", 32'h00000005, {16'h0000, power[0]});
    wr(pos_pid_pkg::A_KI, 32'h00000000);
    wr(pos_pid_pkg::A_KP, 32'h00000002);
    // relative mode: ramped setpoint reaching the target
    wr(pos_pid_pkg::A_CTRL, 32'h00000000);
    wr(pos_pid_pkg::A_MASK, 32'h00000004);
    wr(pos_pid_pkg::A_DEST0, 32'h000000C8);
    ticks(2);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= pos_pid_pkg::A_SETPT0;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk("setpt0 ramping", 32'h00000001, {31'h0, regRdata[15:0] != 16'h00C8});
    wr(pos_pid_pkg::A_VEL, 32'h00000200);
    rdchk("vel live", pos_pid_pkg::A_VEL, 16'h0200);
    ticks(600);
    rdchk("setpt0 end", pos_pid_pkg::A_SETPT0, 16'h00C8);
    rdchk("stat done", pos_pid_pkg::A_STAT, 16'h0004);
    chk("irq done", 32'h00000001, {31'h0, irq});
    wr(pos_pid_pkg::A_STAT, 32'h00000004);
    @(posedge clk);
    #1;
    chk("irq clear", 32'h00000000, {31'h0, irq});
    // current trigger: emergency stop, then limit action
    wr(pos_pid_pkg::A_ITHR, 32'h00000064);
    wr(pos_pid_pkg::A_IDUR, 32'h00000003);
    wr(pos_pid_pkg::A_MASK, 32'h00000001);
    wr(pos_pid_pkg::A_CTRL, 32'h00000002);
    currSet[0] <= 16'h00C8;
    ticks(2);
    chk("estop early", 32'h00000000, {30'h0, emStop});
    ticks(4);
    chk("estop", 32'h00000001, {30'h0, emStop});
    chk("limit none", 32'h00000000, {30'h0, limitSw});
    chk("irq trig", 32'h00000001, {31'h0, irq});
    currSet[0] <= 16'h0000;
    wr(pos_pid_pkg::A_STAT, 32'h00000001);
    wr(pos_pid_pkg::A_CTRL, 32'h00000016);
    ticks(2);
    chk("estop freed", 32'h00000000, {30'h0, emStop});
    currSet[0] <= 16'h00C8;
    ticks(6);
    chk("limit", 32'h00000001, {30'h0, limitSw});
    chk("estop off", 32'h00000000, {30'h0, emStop});
    complete_run();
  end
endmodule
